// ===== verilog/aou_pkg.sv
// Shared constants, codes and range helpers for the analog output unit
package aou_pkg;
    localparam int          SV_W         = 16;
    localparam int          FULL_SCALE   = 4000;
    localparam int          XCHG_WORDS   = 10;
    localparam int          CFG_WORDS    = 100;
    localparam int          MAX_CH       = 8;
    // Set value limits per range family
    localparam logic [15:0] UNI_MIN      = 16'h0000;
    localparam logic [15:0] UNI_MAX      = 16'h0fa0;
    localparam logic [15:0] BIP_MIN      = 16'hf768;
    localparam logic [15:0] BIP_MAX      = 16'h0898;
    // Range codes, two bits per channel
    localparam logic [1:0]  RNG_1_5V     = 2'h0;
    localparam logic [1:0]  RNG_0_10V    = 2'h1;
    localparam logic [1:0]  RNG_0_5V     = 2'h2;
    localparam logic [1:0]  RNG_PM10V    = 2'h3;
    // Hold state codes, two bits per channel
    localparam logic [1:0]  HOLD_CLEAR   = 2'h0;
    localparam logic [1:0]  HOLD_KEEP    = 2'h1;
    localparam logic [1:0]  HOLD_MAX     = 2'h2;
    // Exchange word indices
    localparam logic [3:0]  XW_CONV_EN   = 4'h0;
    localparam logic [3:0]  XW_SV0       = 4'h1;
    localparam logic [3:0]  XW_ALARM     = 4'h9;
    // Configuration block word indices
    localparam logic [6:0]  CW_ENABLE    = 7'h00;
    localparam logic [6:0]  CW_RANGE     = 7'h01;
    localparam logic [6:0]  CW_HOLD      = 7'h02;
    localparam logic [6:0]  CW_LAST      = 7'h63;
    // Conversion time bound
    localparam int          CLK_PERIOD_NS = 20;
    localparam int          CONV_TIME_NS  = 1000000;
    localparam int          CONV_CYC      = CONV_TIME_NS / CLK_PERIOD_NS;
    // Controller register offsets
    localparam logic [7:0]  REG_SV0      = 8'h00;
    localparam logic [7:0]  REG_CONV_EN  = 8'h08;
    localparam logic [7:0]  REG_CTRL     = 8'h09;
    localparam logic [7:0]  REG_ALARM    = 8'h0a;
    localparam logic [7:0]  REG_IRQ_ST   = 8'h0b;
    localparam logic [7:0]  REG_IRQ_CLR  = 8'h0c;
    localparam logic [7:0]  REG_IRQ_EN   = 8'h0d;
    localparam logic [7:0]  REG_CFG0     = 8'h80;
    // Control register bits
    localparam int          CTRL_RUN     = 0;
    localparam int          CTRL_STANDBY = 1;
    localparam int          CTRL_FATAL   = 2;
    localparam int          CTRL_LOAD_ON = 3;
    localparam int          CTRL_RESTART = 4;
    localparam logic [3:0]  CTRL_RST_VAL = 4'h0;
    // Interrupt status bits
    localparam int          IRQ_ALARM    = 0;
    localparam int          IRQ_CFG_DONE = 1;
    localparam int          IRQ_XCHG     = 2;
    localparam int          IRQ_W        = 3;
    localparam int          EXCH_PERIOD  = 64;

    function automatic logic [15:0] aou_rng_low(input logic [1:0] rng);
        return (rng == RNG_PM10V) ? BIP_MIN : UNI_MIN;
    endfunction

    function automatic logic [15:0] aou_rng_high(input logic [1:0] rng);
        return (rng == RNG_PM10V) ? BIP_MAX : UNI_MAX;
    endfunction

    function automatic logic aou_sv_ok(input logic [15:0] sv, input logic [1:0] rng);
        if (rng == RNG_PM10V)
            return ($signed(sv) >= $signed(BIP_MIN)) && ($signed(sv) <= $signed(BIP_MAX));
        return sv <= UNI_MAX;
    endfunction
endpackage

// ===== verilog/aou_link_if.sv
// Exchange link between the controller CPU end and the output unit end
interface aou_link_if;
    logic        xchg_stb;     // Exchange word strobe
    logic [3:0]  xchg_idx;     // Exchange word index
    logic [15:0] xchg_data;    // Exchange word data
    logic        xchg_end;     // End of exchange cycle
    logic [15:0] alarm_word;   // Alarm flags back to host
    logic        cfg_stb;      // Configuration word strobe
    logic [6:0]  cfg_idx;      // Configuration word index
    logic [15:0] cfg_data;     // Configuration word data
    logic        cfg_end;      // End of configuration block
    logic        plc_fatal;    // Host fatal error level
    logic        plc_standby;  // Host standby level
    logic        load_on;      // Host load output level

    modport dev (input xchg_stb, xchg_idx, xchg_data, xchg_end, cfg_stb, cfg_idx,
                 cfg_data, cfg_end, plc_fatal, plc_standby, load_on, output alarm_word);
    modport host (output xchg_stb, xchg_idx, xchg_data, xchg_end, cfg_stb, cfg_idx,
                  cfg_data, cfg_end, plc_fatal, plc_standby, load_on, input alarm_word);
endinterface

// ===== verilog/aou_dev.sv
// Output unit end: configuration, set value checking and hold control
module aou_dev
    import aou_pkg::*;
#(
    parameter int NUM_CH = MAX_CH
) (
    input  wire logic                   REF_CLK,    // 50 MHz clock
    input  wire logic                   RST_B,      // Async reset, active low
    aou_link_if.dev                     LNK,        // Link to host
    input  wire logic                   ADJ_MODE,   // Adjustment mode pin
    input  wire logic [2:0]             ADJ_CH,     // Channel under adjustment
    output logic      [NUM_CH*16-1:0]   DAC_CODE,   // Per-channel output codes
    output logic      [NUM_CH-1:0]      HOLD_ACT,   // Channel in hold state
    output logic                        CFG_VALID   // Config block received
);
    logic               adj_mode_s1, adj_mode_s2;
    logic [2:0]         adj_ch_s1, adj_ch_s2;
    logic [NUM_CH-1:0]  cfg_en_r;
    logic [15:0]        cfg_rng_r;
    logic [15:0]        cfg_hold_r;
    logic               cfg_valid_r;
    logic [NUM_CH-1:0]  conv_en_sh_r, conv_en_r;
    logic [15:0]        sv_sh_r [NUM_CH];
    logic [15:0]        sv_r    [NUM_CH];
    logic [NUM_CH-1:0]  sv_err;
    logic [NUM_CH-1:0]  hold_nxt;
    logic [NUM_CH-1:0]  adj_hold;
    logic               host_hold;
    logic [15:0]        dac_r   [NUM_CH];
    logic [15:0]        dac_nxt [NUM_CH];
    logic [15:0]        alarm_r;

    // Pins from outside, two stages before use
    always_ff @(posedge REF_CLK or negedge RST_B) begin
        if (!RST_B) begin
            adj_mode_s1 <= 1'b0;
            adj_mode_s2 <= 1'b0;
        end else begin
            adj_mode_s1 <= ADJ_MODE;
            adj_mode_s2 <= adj_mode_s1;
        end
    end

    // Channel select synced bit by bit; changing it while adjusting
    // may show a stray channel for one cycle
    always_ff @(posedge REF_CLK or negedge RST_B) begin
        if (!RST_B) begin
            adj_ch_s1 <= 3'h0;
            adj_ch_s2 <= 3'h0;
        end else begin
            adj_ch_s1 <= ADJ_CH;
            adj_ch_s2 <= adj_ch_s1;
        end
    end

    // Config taken only from the block stream; kept until the next block
    always_ff @(posedge REF_CLK or negedge RST_B) begin
        if (!RST_B) begin
            cfg_en_r   <= '0;
            cfg_rng_r  <= 16'h0000;
            cfg_hold_r <= 16'h0000;
        end else if (LNK.cfg_stb) begin
            unique case (LNK.cfg_idx)
                CW_ENABLE: cfg_en_r   <= LNK.cfg_data[NUM_CH-1:0];
                CW_RANGE:  cfg_rng_r  <= LNK.cfg_data;
                CW_HOLD:   cfg_hold_r <= LNK.cfg_data;
                default: ;
            endcase
        end
    end

    // Valid drops at the first word and rises with the last, so a cut
    // block leaves every channel held rather than half configured
    always_ff @(posedge REF_CLK or negedge RST_B) begin
        if (!RST_B)
            cfg_valid_r <= 1'b0;
        else if (LNK.cfg_end)
            cfg_valid_r <= 1'b1;
        else if (LNK.cfg_stb)
            cfg_valid_r <= 1'b0;
    end

    // Shadow words filled during the exchange, made active at its end
    always_ff @(posedge REF_CLK or negedge RST_B) begin
        if (!RST_B) begin
            conv_en_sh_r <= '0;
            conv_en_r    <= '0;
            for (int i = 0; i < NUM_CH; i++) begin
                sv_sh_r[i] <= 16'h0000;
                sv_r[i]    <= 16'h0000;
            end
        end else begin
            if (LNK.xchg_stb) begin
                if (LNK.xchg_idx == XW_CONV_EN)
                    conv_en_sh_r <= LNK.xchg_data[NUM_CH-1:0];
                for (int i = 0; i < NUM_CH; i++) begin
                    if (LNK.xchg_idx == XW_SV0 + 4'(i))
                        sv_sh_r[i] <= LNK.xchg_data;
                end
            end
            if (LNK.xchg_end) begin
                conv_en_r <= conv_en_sh_r;
                for (int i = 0; i < NUM_CH; i++)
                    sv_r[i] <= sv_sh_r[i];
            end
        end
    end

    // Code driven by a held channel; keep repeats what the pin shows now
    function automatic logic [15:0] held_code(input logic [1:0]  hst,
                                              input logic [1:0]  rng,
                                              input logic [15:0] last);
        unique case (hst)
            HOLD_MAX:  return aou_rng_high(rng);
            HOLD_KEEP: return last;
            default:   return aou_rng_low(rng);                     // clear_output_state
        endcase
    endfunction

    // Errors count only on configured, converting channels
    always_comb begin
        for (int i = 0; i < NUM_CH; i++)
            sv_err[i] = cfg_valid_r && cfg_en_r[i] && conv_en_r[i]
                        && !aou_sv_ok(sv_r[i], cfg_rng_r[2*i +: 2]);
    end

    // Causes from the host hold every channel at once
    assign host_hold = LNK.plc_fatal || LNK.plc_standby
                       || !LNK.load_on;

    // In adjust mode only the selected channel follows its set value
    always_comb begin
        for (int i = 0; i < NUM_CH; i++)
            adj_hold[i] = adj_mode_s2 && (adj_ch_s2 != 3'(i));
    end

    // Hold decision per channel; unconfigured channels stay held
    always_comb begin
        for (int i = 0; i < NUM_CH; i++) begin
            logic [1:0] rng;
            logic [1:0] hst;
            rng = cfg_rng_r[2*i +: 2];
            hst = cfg_hold_r[2*i +: 2];
            hold_nxt[i] = !cfg_valid_r || !cfg_en_r[i]
                          || !conv_en_r[i]
                          || adj_hold[i] || sv_err[i] || host_hold;
            if (hold_nxt[i])
                dac_nxt[i] = held_code(hst, rng, dac_r[i]);
            else
                dac_nxt[i] = sv_r[i];
        end
    end

    // Outputs refresh every cycle, well inside the conversion bound
    always_ff @(posedge REF_CLK or negedge RST_B) begin
        if (!RST_B)
            HOLD_ACT <= '1;
        else
            HOLD_ACT <= hold_nxt;
    end

    always_ff @(posedge REF_CLK or negedge RST_B) begin
        if (!RST_B) begin
            for (int i = 0; i < NUM_CH; i++)
                dac_r[i] <= 16'h0000;
        end else begin
            for (int i = 0; i < NUM_CH; i++)
                dac_r[i] <= dac_nxt[i];
        end
    end

    // Alarm flags are registered on the same edge as the codes; upper bits read as zero
    always_ff @(posedge REF_CLK or negedge RST_B) begin
        if (!RST_B)
            alarm_r <= 16'h0000;
        else
            alarm_r <= 16'(sv_err);
    end

    // Flat code bus, channel i in its own 16-bit slice
    always_comb begin
        for (int i = 0; i < NUM_CH; i++)
            DAC_CODE[16*i +: 16] = dac_r[i];
    end

    assign LNK.alarm_word = alarm_r;
    assign CFG_VALID      = cfg_valid_r;
endmodule

// ===== verilog/aou_host.sv
// Controller CPU end: register port, config block and cyclic exchange
module aou_host
    import aou_pkg::*;
#(
    parameter int NUM_CH = MAX_CH,
    parameter int PERIOD = EXCH_PERIOD
) (
    input  wire logic        REF_CLK,  // 50 MHz clock
    input  wire logic        RST_B,    // Async reset, active low
    input  wire logic [7:0]  ADDR,     // Register address
    input  wire logic [15:0] WDATA,    // Write data
    input  wire logic        WR,       // Write strobe
    input  wire logic        RD,       // Read strobe
    output logic      [15:0] RDATA,    // Read data, cycle after RD
    output logic             IRQ,      // Level interrupt
    aou_link_if.host         LNK       // Link to output unit
);
    typedef enum logic [1:0] {ST_CFG, ST_IDLE, ST_XCHG} aou_hst_type;

    aou_hst_type        st_r;
    logic [15:0]        sv_r [NUM_CH];
    logic [15:0]        cfg_mem [CFG_WORDS];
    logic [NUM_CH-1:0]  conv_en_r;
    logic [3:0]         ctrl_r;
    logic               restart_r;
    logic [15:0]        alarm_r;
    logic [IRQ_W-1:0]   irq_st_r, irq_en_r, irq_set;
    logic [6:0]         cnt_r;
    logic [15:0]        wait_r;
    logic               x_stb_r, x_end_r, c_stb_r, c_end_r;
    logic [3:0]         x_idx_r;
    logic [6:0]         c_idx_r;
    logic [15:0]        x_dat_r, c_dat_r;
    logic               wr_ctrl, wr_cfg;

    assign wr_ctrl = WR && (ADDR == REG_CTRL);
    assign wr_cfg  = WR && (ADDR >= REG_CFG0) && (ADDR - REG_CFG0 < 8'(CFG_WORDS));

    always_ff @(posedge REF_CLK) begin
        if (wr_cfg)
            cfg_mem[7'(ADDR - REG_CFG0)] <= WDATA;
    end

    always_ff @(posedge REF_CLK or negedge RST_B) begin
        if (!RST_B) begin
            for (int i = 0; i < NUM_CH; i++)
                sv_r[i] <= 16'h0000;
            conv_en_r <= '0;
            ctrl_r    <= CTRL_RST_VAL;
            irq_en_r  <= '0;
        end else begin
            for (int i = 0; i < NUM_CH; i++) begin
                if (WR && ADDR == REG_SV0 + 8'(i))
                    sv_r[i] <= WDATA;
            end
            if (WR && ADDR == REG_CONV_EN)
                conv_en_r <= WDATA[NUM_CH-1:0];
            if (wr_ctrl) begin
                ctrl_r <= WDATA[3:0];
                if (ctrl_r[CTRL_RUN] && !WDATA[CTRL_RUN])
                    conv_en_r <= '0;
            end
            if (WR && ADDR == REG_IRQ_EN)
                irq_en_r <= WDATA[IRQ_W-1:0];
        end
    end

    // Sequencer: config block after reset or restart, then cyclic exchange
    always_ff @(posedge REF_CLK or negedge RST_B) begin
        if (!RST_B) begin
            st_r      <= ST_CFG;
            restart_r <= 1'b0;
            cnt_r     <= 7'h00;
            wait_r    <= 16'h0000;
            x_stb_r   <= 1'b0;
            x_end_r   <= 1'b0;
            x_idx_r   <= 4'h0;
            x_dat_r   <= 16'h0000;
            c_stb_r   <= 1'b0;
            c_end_r   <= 1'b0;
            c_idx_r   <= 7'h00;
            c_dat_r   <= 16'h0000;
        end else begin
            x_stb_r <= 1'b0;
            // End trails the last word so its data is shadowed before the swap
            x_end_r <= x_stb_r && (x_idx_r == 4'(NUM_CH));
            c_stb_r <= 1'b0;
            c_end_r <= 1'b0;
            if (wr_ctrl && WDATA[CTRL_RESTART])
                restart_r <= 1'b1;
            unique case (st_r)
                ST_CFG: begin
                    c_stb_r <= 1'b1;
                    c_idx_r <= cnt_r;
                    c_dat_r <= cfg_mem[cnt_r];
                    if (cnt_r == CW_LAST) begin
                        cnt_r <= 7'h00;
                        st_r  <= ST_IDLE;
                    end else begin
                        cnt_r <= cnt_r + 7'h01;
                    end
                    c_end_r <= (cnt_r == CW_LAST);
                end
                ST_IDLE: begin
                    wait_r <= wait_r + 16'h0001;
                    if (restart_r && !(wr_ctrl && WDATA[CTRL_RESTART])) begin
                        restart_r <= 1'b0;
                        wait_r    <= 16'h0000;
                        st_r      <= ST_CFG;
                    end else if (wait_r >= 16'(PERIOD - 1)) begin
                        wait_r <= 16'h0000;
                        st_r   <= ST_XCHG;
                    end
                end
                ST_XCHG: begin
                    x_stb_r <= 1'b1;
                    x_idx_r <= cnt_r[3:0];
                    if (cnt_r == 7'h00)
                        x_dat_r <= 16'(conv_en_r);
                    else
                        x_dat_r <= sv_r[cnt_r[2:0] - 3'h1];
                    if (cnt_r == 7'(NUM_CH)) begin
                        cnt_r   <= 7'h00;
                        st_r    <= ST_IDLE;
                    end else begin
                        cnt_r <= cnt_r + 7'h01;
                    end
                end
            endcase
        end
    end

    // Alarm word of the exchange is taken at cycle end
    assign irq_set[IRQ_ALARM]    = x_end_r && |(LNK.alarm_word & ~alarm_r);
    assign irq_set[IRQ_CFG_DONE] = c_end_r;
    assign irq_set[IRQ_XCHG]     = x_end_r;

    always_ff @(posedge REF_CLK or negedge RST_B) begin
        if (!RST_B) begin
            alarm_r  <= 16'h0000;
            irq_st_r <= '0;
            IRQ      <= 1'b0;
            RDATA    <= 16'h0000;
        end else begin
            if (x_end_r)
                alarm_r <= LNK.alarm_word;
            // Set wins over a clear in the same cycle
            irq_st_r <= (irq_st_r & ~((WR && ADDR == REG_IRQ_CLR) ? WDATA[IRQ_W-1:0] : '0))
                        | irq_set;
            IRQ      <= |(irq_st_r & irq_en_r);
            RDATA    <= 16'h0000;
            if (RD) begin
                if (ADDR < REG_SV0 + 8'(NUM_CH))
                    RDATA <= sv_r[ADDR[2:0]];
                else if (ADDR == REG_CONV_EN)
                    RDATA <= 16'(conv_en_r);
                else if (ADDR == REG_CTRL)
                    RDATA <= {12'h000, ctrl_r};
                else if (ADDR == REG_ALARM)
                    RDATA <= alarm_r;
                else if (ADDR == REG_IRQ_ST)
                    RDATA <= 16'(irq_st_r);
                else if (ADDR == REG_IRQ_EN)
                    RDATA <= 16'(irq_en_r);
                else if (ADDR >= REG_CFG0 && ADDR - REG_CFG0 < 8'(CFG_WORDS))
                    RDATA <= cfg_mem[7'(ADDR - REG_CFG0)];
            end
        end
    end

    assign LNK.xchg_stb    = x_stb_r;
    assign LNK.xchg_idx    = x_idx_r;
    assign LNK.xchg_data   = x_dat_r;
    assign LNK.xchg_end    = x_end_r;
    assign LNK.cfg_stb     = c_stb_r;
    assign LNK.cfg_idx     = c_idx_r;
    assign LNK.cfg_data    = c_dat_r;
    assign LNK.cfg_end     = c_end_r;
    assign LNK.plc_fatal   = ctrl_r[CTRL_FATAL];
    assign LNK.plc_standby = ctrl_r[CTRL_STANDBY];
    assign LNK.load_on     = ctrl_r[CTRL_LOAD_ON];
endmodule

// ===== verif/aou_checker.sv
// Link protocol assertions between host end and output unit end
module aou_checker
    import aou_pkg::*;
#(
    parameter int NUM_CH = MAX_CH
) (
    input wire logic        REF_CLK,     // Clock
    input wire logic        RST_B,       // Async reset, active low
    input wire logic        xchg_stb,    // Exchange word strobe
    input wire logic [3:0]  xchg_idx,    // Exchange word index
    input wire logic        xchg_end,    // End of exchange
    input wire logic [15:0] alarm_word,  // Alarm flags
    input wire logic        cfg_stb,     // Config word strobe
    input wire logic [6:0]  cfg_idx,     // Config word index
    input wire logic        cfg_end,     // End of config block
    input wire logic        load_on      // Load output level
);
    timeunit 1ns;
    timeprecision 1ps;

    localparam logic [3:0] LAST = 4'(NUM_CH);

    default clocking cb @(posedge REF_CLK);
    endclocking
    default disable iff (!RST_B);

    cfg_last_a: assert property (
        cfg_end |-> cfg_stb && cfg_idx == CW_LAST) else $error("cfg end off last word");
    cfg_seq_a: assert property (
        cfg_stb && cfg_idx != CW_LAST |=> cfg_stb && cfg_idx == $past(cfg_idx) + 7'h01)
        else $error("cfg words not consecutive");
    cfg_first_a: assert property (
        $rose(cfg_stb) |-> cfg_idx == 7'h00) else $error("cfg block not from word 0");
    cfg_excl_a: assert property (
        cfg_stb |-> !xchg_stb) else $error("exchange during cfg block");
    xchg_span_a: assert property (
        xchg_stb |-> xchg_idx <= LAST) else $error("exchange index out of span");
    xchg_seq_a: assert property (
        xchg_stb && xchg_idx != LAST |=> xchg_stb && xchg_idx == $past(xchg_idx) + 4'h1)
        else $error("exchange words not consecutive");
    xchg_first_a: assert property (
        $rose(xchg_stb) |-> xchg_idx == 4'h0) else $error("exchange not from word 0");
    xchg_end_a: assert property (
        xchg_stb && xchg_idx == LAST |=> xchg_end && !xchg_stb)
        else $error("no end after last word");
    end_cause_a: assert property (
        xchg_end |-> $past(xchg_stb) && $past(xchg_idx) == LAST)
        else $error("stray exchange end");
    xchg_gap_a: assert property (
        xchg_end |=> !xchg_stb [*4]) else $error("exchange restarted too soon");

    cover property (cfg_end);
    cover property (xchg_end);
    cover property ($rose(alarm_word != 16'h0000));
    cover property ($fell(load_on));
endmodule

// ===== verif/analog_output_unit_control_test.sv
// Self-checking bench: host end and output unit end joined by the link
module analog_output_unit_control_test;
    timeunit 1ns;
    timeprecision 1ps;
    import aou_pkg::*;

    logic         clk;
    logic         rst_b;
    logic [7:0]   addr;
    logic [15:0]  wdata;
    logic         wr_s;
    logic         rd_s;
    logic [15:0]  rdata;
    logic         irq;
    logic         adj_mode;
    logic [2:0]   adj_ch;
    logic [127:0] dac;
    logic [7:0]   hold;
    logic         cfg_valid;
    logic [15:0]  v;
    int           failures;
    int           tests_run;

    aou_link_if lnk ();
    aou_host #(.NUM_CH(8), .PERIOD(8)) i_aou_host (.REF_CLK(clk), .RST_B(rst_b), .ADDR(addr),
        .WDATA(wdata), .WR(wr_s), .RD(rd_s), .RDATA(rdata), .IRQ(irq), .LNK(lnk.host));
    aou_dev #(.NUM_CH(8)) i_aou_dev (.REF_CLK(clk), .RST_B(rst_b), .LNK(lnk.dev),
        .ADJ_MODE(adj_mode), .ADJ_CH(adj_ch), .DAC_CODE(dac), .HOLD_ACT(hold),
        .CFG_VALID(cfg_valid));
    aou_checker #(.NUM_CH(8)) i_aou_checker (.REF_CLK(clk), .RST_B(rst_b),
        .xchg_stb(lnk.xchg_stb), .xchg_idx(lnk.xchg_idx), .xchg_end(lnk.xchg_end),
        .alarm_word(lnk.alarm_word), .cfg_stb(lnk.cfg_stb), .cfg_idx(lnk.cfg_idx),
        .cfg_end(lnk.cfg_end), .load_on(lnk.load_on));

    task automatic chk(string what, logic [15:0] seen, logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            failures++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic end_sim();
        $display("checks %0d failures %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic wr(logic [7:0] a, logic [15:0] d);
        addr <= a;
        wdata <= d;
        wr_s <= 1'b1;
        @(posedge clk);
        wr_s <= 1'b0;
        @(posedge clk);
    endtask

    // Read data stand only in the cycle after the strobe
    task automatic rd(logic [7:0] a);
        addr <= a;
        rd_s <= 1'b1;
        @(posedge clk);
        rd_s <= 1'b0;
        #1 v = rdata;
        @(posedge clk);
    endtask

    task automatic sv4(logic [15:0] c0, c1, c2, c3);
        wr(REG_SV0, c0);
        wr(REG_SV0 + 8'h01, c1);
        wr(REG_SV0 + 8'h02, c2);
        wr(REG_SV0 + 8'h03, c3);
    endtask

    task automatic wait_cfg(logic lvl);
        int n = 0;
        while (cfg_valid !== lvl) begin
            @(posedge clk);
            n++;
            if (n > 500) begin
                failures++;
                end_sim();
            end
        end
    endtask

    // Two exchange ends: the first may carry words taken before our writes
    task automatic settle();
        int n = 0;
        int e = 0;
        while (e < 2) begin
            @(posedge clk);
            #1;
            if (lnk.xchg_end === 1'b1) e++;
            n++;
            if (n > 400) begin
                failures++;
                end_sim();
            end
        end
        repeat (2) @(posedge clk);
        #1;
    endtask

    task automatic outs(logic [7:0] h, logic [15:0] c0, c1, c2, c3);
        chk("hold", {8'h00, hold}, {8'h00, h});
        chk("ch0", dac[15:0], c0);
        chk("ch1", dac[31:16], c1);
        chk("ch2", dac[47:32], c2);
        chk("ch3", dac[63:48], c3);
    endtask

    // Ranges 1-5V, 0-10V, 0-5V, +-10V; holds clear, keep, max, max
    task automatic sc_config();
        wait_cfg(1'b1);
        wr(REG_CFG0, 16'h00ff);
        wr(REG_CFG0 + 8'h01, 16'h00e4);
        wr(REG_CFG0 + 8'h02, 16'h00a4);
        wr(REG_CTRL, 16'h0010);
        wait_cfg(1'b0);
        wait_cfg(1'b1);
        chk("cfg valid", {15'h0000, cfg_valid}, 16'h0001);
        rd(REG_IRQ_ST);
        chk("cfg irq", v & 16'h0002, 16'h0002);
        rd(REG_CFG0 + 8'h01);
        chk("range word", v, 16'h00e4);
        rd(8'h40);
        chk("unmapped", v, 16'h0000);
    endtask

    task automatic sc_convert();
        wr(REG_IRQ_EN, 16'h0001);
        wr(REG_CTRL, 16'h0009);
        for (int i = 4; i < 8; i++) wr(REG_SV0 + 8'(i), 16'h07d0);
        sv4(16'h0fa0, 16'h0123, 16'h0456, 16'hf768);
        wr(REG_CONV_EN, 16'h00ff);
        settle();
        outs(8'h00, 16'h0fa0, 16'h0123, 16'h0456, 16'hf768);
        chk("ch7", dac[127:112], 16'h07d0);
        chk("no alarm", lnk.alarm_word, 16'h0000);
        rd(REG_IRQ_ST);
        chk("xchg irq", v & 16'h0004, 16'h0004);
    endtask

    task automatic sc_enable();
        wr(REG_CONV_EN, 16'h00f0);
        settle();
        outs(8'h0f, 16'h0000, 16'h0123, 16'h0fa0, 16'h0898);
        wr(REG_CONV_EN, 16'h00ff);
    endtask

    task automatic sc_error();
        sv4(16'h0fa1, 16'hffff, 16'h0456, 16'hf767);
        settle();
        outs(8'h0b, 16'h0000, 16'h0123, 16'h0456, 16'h0898);
        chk("alarm link", lnk.alarm_word, 16'h000b);
        settle();
        rd(REG_ALARM);
        chk("alarm reg", v, 16'h000b);
        chk("irq on", {15'h0000, irq}, 16'h0001);
        wr(REG_IRQ_CLR, 16'h0001);
        rd(REG_IRQ_ST);
        chk("irq st", v & 16'h0001, 16'h0000);
        chk("irq off", {15'h0000, irq}, 16'h0000);
        sv4(16'h0fa0, 16'h0123, 16'h0456, 16'hf768);
        settle();
        outs(8'h00, 16'h0fa0, 16'h0123, 16'h0456, 16'hf768);
    endtask

    // Load off, standby, fatal, with the run bit kept set
    task automatic sc_levels();
        logic [15:0] ctl [3] = '{16'h0001, 16'h000b, 16'h000d};
        for (int i = 0; i < 3; i++) begin
            wr(REG_CTRL, ctl[i]);
            settle();
            outs(8'hff, 16'h0000, 16'h0123, 16'h0fa0, 16'h0898);
        end
        wr(REG_CTRL, 16'h0009);
    endtask

    task automatic sc_adjust();
        adj_ch <= 3'h2;
        adj_mode <= 1'b1;
        settle();
        outs(8'hfb, 16'h0000, 16'h0123, 16'h0456, 16'h0898);
        adj_mode <= 1'b0;
        settle();
        outs(8'h00, 16'h0fa0, 16'h0123, 16'h0456, 16'hf768);
    endtask

    task automatic sc_run_off();
        wr(REG_CTRL, 16'h0008);
        settle();
        rd(REG_CONV_EN);
        chk("enables", v, 16'h0000);
        outs(8'hff, 16'h0000, 16'h0123, 16'h0fa0, 16'h0898);
    endtask

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    initial begin
        rst_b = 1'b0;
        addr = 8'h00;
        wdata = 16'h0000;
        wr_s = 1'b0;
        rd_s = 1'b0;
        adj_mode = 1'b0;
        adj_ch = 3'h0;
        failures = 0;
        tests_run = 0;
        repeat (10) @(posedge clk);
        chk("reset hold", {8'h00, hold}, 16'h00ff);
        rst_b <= 1'b1;
        sc_config();
        sc_convert();
        sc_enable();
        sc_error();
        sc_levels();
        sc_adjust();
        sc_run_off();
        end_sim();
    end
endmodule
